// file: pkg/irq_cfg_pkg.sv
// register map, field layout and reset values of the interrupt configuration slice
// assumes a 32-bit AXI4-Lite master and event sources on the same clock
package irq_cfg_pkg;

    // ---------------------------------------------------------------
    // bus geometry
    // ---------------------------------------------------------------
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam int REG_W = 16;

    // ---------------------------------------------------------------
    // byte offsets
    // ---------------------------------------------------------------
    localparam logic [11:0] OFS_ENABLE_WORD4 = 12'h000;
    localparam logic [11:0] OFS_PRIO_WORD0 = 12'h004;
    localparam logic [11:0] OFS_PRIO_WORD1 = 12'h008;
    localparam logic [11:0] OFS_PRIO_WORD2 = 12'h00C;
    localparam logic [11:0] OFS_PRIO_WORD3 = 12'h010;
    localparam logic [11:0] OFS_EVENT_STATUS = 12'h014;
    localparam logic [11:0] OFS_EVENT_MASK = 12'h018;
    localparam logic [11:0] OFS_ENABLE_EXT = 12'h01C;

    // ---------------------------------------------------------------
    // source numbering
    // ---------------------------------------------------------------
    localparam int N_EN_SRC = 6;
    localparam int N_PRIO_SRC = 15;
    localparam int N_SRC = 21;
    localparam int N_PRIO_WORDS = 4;
    localparam int FIELDS_PER_WORD = 4;
    localparam int PRIO_W = 3;

    // enable-word sources, in source order
    localparam int SRC_CAN2_TX = 0;
    localparam int SRC_CAN1_TX = 1;
    localparam int SRC_DMA_CH7_DONE = 2;
    localparam int SRC_DMA_CH6_DONE = 3;
    localparam int SRC_UART2_ERR = 4;
    localparam int SRC_UART1_ERR = 5;

    // bit positions in source_enable_word4
    localparam int BIT_CAN2_TX_REQ_EN = 7;
    localparam int BIT_CAN1_TX_REQ_EN = 6;
    localparam int BIT_DMA_CH7_DONE_EN = 5;
    localparam int BIT_DMA_CH6_DONE_EN = 4;
    localparam int BIT_UART2_ERR_EN = 2;
    localparam int BIT_UART1_ERR_EN = 1;
    localparam logic [15:0] ENABLE4_MASK = 16'h00F6;

    // priority sources: field k sits in word k/4, slot k%4 from the low end
    localparam int PF_EXT_IRQ0 = 0;
    localparam int PF_INCAP1 = 1;
    localparam int PF_OUTCMP1 = 2;
    localparam int PF_TIMER1 = 3;
    localparam int PF_DMA_CH0_DONE = 4;
    localparam int PF_INCAP2 = 5;
    localparam int PF_OUTCMP2 = 6;
    localparam int PF_TIMER2 = 7;
    localparam int PF_TIMER3 = 8;
    localparam int PF_SPI1_ERR = 9;
    localparam int PF_SPI1_EVENT = 10;
    localparam int PF_UART1_RX = 11;
    localparam int PF_UART1_TX = 12;
    localparam int PF_ADC1_DONE = 13;
    localparam int PF_DMA_CH1_DONE = 14;
    localparam int FIELD_STRIDE = 4;

    // ---------------------------------------------------------------
    // reset values and codes
    // ---------------------------------------------------------------
    localparam logic [2:0] PRIO_RESET = 3'h4;
    localparam logic [2:0] PRIO_OFF = 3'h0;
    localparam logic [2:0] PRIO_ENWORD_SRC = 3'h4;
    localparam logic [15:0] ENABLE4_RESET = 16'h0000;
    localparam logic [14:0] ENABLE_EXT_RESET = 15'h0000;
    localparam logic [20:0] MASK_RESET = 21'h00_0000;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : irq_cfg_pkg

// file: rtl/axil_port.sv
// AXI4-Lite slave handshake front end: one write and one read in flight
// assumes the register side answers a strobe in the same cycle
`timescale 1ns/1ps
module axil_port
    import irq_cfg_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic cken,
    input wire logic [ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [DATA_W-1:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [DATA_W-1:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    output logic wr_stb,
    output logic [ADDR_W-1:0] wr_addr,
    output logic [DATA_W-1:0] wr_data,
    output logic [3:0] wr_strb,
    input wire logic wr_err,
    output logic rd_stb,
    output logic [ADDR_W-1:0] rd_addr,
    input wire logic [DATA_W-1:0] rd_data,
    input wire logic rd_err
);

    logic aw_held;
    logic w_held;
    logic ar_held;
    wire aw_take = awvalid & awready & cken;
    wire w_take = wvalid & wready & cken;
    wire ar_take = arvalid & arready & cken;

    assign awready = ~aw_held & ~bvalid;
    assign wready = ~w_held & ~bvalid;
    assign arready = ~ar_held & ~rvalid;
    assign wr_stb = aw_held & w_held & ~bvalid & cken;
    assign rd_stb = ar_held & ~rvalid & cken;

    // ---------------------------------------------------------------
    // write channel
    // ---------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            bvalid <= 1'b0;
            bresp <= RESP_OKAY;
            wr_addr <= '0;
            wr_data <= '0;
            wr_strb <= '0;
        end else if (cken) begin
            if (aw_take) begin
                aw_held <= 1'b1;
                wr_addr <= awaddr;
            end
            if (w_take) begin
                w_held <= 1'b1;
                wr_data <= wdata;
                wr_strb <= wstrb;
            end
            if (wr_stb) begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                bvalid <= 1'b1;
                bresp <= wr_err ? RESP_SLVERR : RESP_OKAY;
            end else if (bvalid && bready) begin
                bvalid <= 1'b0;
            end
        end
    end

    // ---------------------------------------------------------------
    // read channel
    // ---------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ar_held <= 1'b0;
            rvalid <= 1'b0;
            rresp <= RESP_OKAY;
            rdata <= '0;
            rd_addr <= '0;
        end else if (cken) begin
            if (ar_take) begin
                ar_held <= 1'b1;
                rd_addr <= araddr;
            end
            if (rd_stb) begin
                ar_held <= 1'b0;
                rvalid <= 1'b1;
                rdata <= rd_data;
                rresp <= rd_err ? RESP_SLVERR : RESP_OKAY;
            end else if (rvalid && rready) begin
                rvalid <= 1'b0;
            end
        end
    end

endmodule : axil_port

// file: rtl/irq_enable_priority_regs.sv
// enable and priority configuration of an interrupt controller slice,
// with sticky event capture, masking and request gating toward arbitration
// assumes event pulses come from logic on aclk and an AXI4-Lite master
`timescale 1ns/1ps

// Contract
// - an enable bit of one lets its source's request reach arbitration, zero blocks it.
// - enable word 4 bits: CAN2 tx 7, CAN1 tx 6, DMA7 5, DMA6 4, UART2 error 2, UART1 error 1.
// - unimplemented bits of enable and priority words always read zero.
// - each priority field is three bits and 111 is level 7, the highest.
// - 001 is level 1, the lowest active, and other codes map to their own value.
// - a priority of 000 disables the source whatever its enable bit says; the code blocks only arb_req, irq still follows event_mask.
// - priority fields sit at bits 14-12, 10-8, 6-4 and 2-0, with bits 15, 11, 7 and 3 empty; word 3 has no 14-12 field, its bits 15-11 are empty.
// - at reset every priority field loads 100 and every enable bit clears.
// - priority word 0 holds, high to low, timer1, out compare 1, in capture 1, ext irq 0.
// - priority word 1 holds, high to low, timer2, out compare 2, in capture 2, DMA channel 0.
// - priority word 2 holds UART1 receive, SPI1 event, SPI1 error, timer3 from high to low.
// - the third field of word 0 is the input capture 1 priority with the common encoding.
module irq_enable_priority_regs
    import irq_cfg_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic cken,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [DATA_W-1:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [DATA_W-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [N_SRC-1:0] src_event,
    output logic [N_SRC-1:0] arb_req,
    output logic [N_SRC*PRIO_W-1:0] arb_level,
    output logic irq
);

    // ---------------------------------------------------------------
    // helpers
    // ---------------------------------------------------------------

    // enable-word bit that belongs to an enable-word source
    function automatic int enable4_bit(input int src);
        case (src)
            SRC_CAN2_TX: enable4_bit = BIT_CAN2_TX_REQ_EN;
            SRC_CAN1_TX: enable4_bit = BIT_CAN1_TX_REQ_EN;
            SRC_DMA_CH7_DONE: enable4_bit = BIT_DMA_CH7_DONE_EN;
            SRC_DMA_CH6_DONE: enable4_bit = BIT_DMA_CH6_DONE_EN;
            SRC_UART2_ERR: enable4_bit = BIT_UART2_ERR_EN;
            default: enable4_bit = BIT_UART1_ERR_EN;
        endcase
    endfunction : enable4_bit

    // any nonzero code is an active level equal to its value
    function automatic logic level_active(input logic [2:0] level);
        level_active = (level != PRIO_OFF);
    endfunction : level_active

    // merge 16-bit write data into a register under the low byte lanes
    function automatic logic [15:0] lane_merge(
        input logic [15:0] old_val,
        input logic [31:0] data,
        input logic [3:0] strb
    );
        logic [15:0] res;
        res = old_val;
        if (strb[0]) begin
            res[7:0] = data[7:0];
        end
        if (strb[1]) begin
            res[15:8] = data[15:8];
        end
        lane_merge = res;
    endfunction : lane_merge

    // ---------------------------------------------------------------
    // bus front end
    // ---------------------------------------------------------------
    logic wr_stb;
    logic [ADDR_W-1:0] wr_addr;
    logic [DATA_W-1:0] wr_data;
    logic [3:0] wr_strb;
    logic wr_err;
    logic rd_stb;
    logic [ADDR_W-1:0] rd_addr;
    logic [DATA_W-1:0] rd_data;
    logic rd_err;

    axil_port u_port (
        .aclk(aclk),
        .aresetn(aresetn),
        .cken(cken),
        .awaddr(s_axi_awaddr),
        .awvalid(s_axi_awvalid),
        .awready(s_axi_awready),
        .wdata(s_axi_wdata),
        .wstrb(s_axi_wstrb),
        .wvalid(s_axi_wvalid),
        .wready(s_axi_wready),
        .bresp(s_axi_bresp),
        .bvalid(s_axi_bvalid),
        .bready(s_axi_bready),
        .araddr(s_axi_araddr),
        .arvalid(s_axi_arvalid),
        .arready(s_axi_arready),
        .rdata(s_axi_rdata),
        .rresp(s_axi_rresp),
        .rvalid(s_axi_rvalid),
        .rready(s_axi_rready),
        .wr_stb(wr_stb),
        .wr_addr(wr_addr),
        .wr_data(wr_data),
        .wr_strb(wr_strb),
        .wr_err(wr_err),
        .rd_stb(rd_stb),
        .rd_addr(rd_addr),
        .rd_data(rd_data),
        .rd_err(rd_err)
    );

    // ---------------------------------------------------------------
    // register state
    // ---------------------------------------------------------------
    logic [15:0] enable_word4;
    logic [14:0] enable_ext;
    logic [2:0] prio [N_PRIO_SRC];
    logic [N_SRC-1:0] pending;
    logic [N_SRC-1:0] event_mask;

    // ---------------------------------------------------------------
    // address decode
    // ---------------------------------------------------------------
    wire wr_is_en4 = (wr_addr == OFS_ENABLE_WORD4);
    wire wr_is_mask = (wr_addr == OFS_EVENT_MASK);
    wire wr_is_ext = (wr_addr == OFS_ENABLE_EXT);
    wire wr_is_status = (wr_addr == OFS_EVENT_STATUS);
    wire [3:0] wr_is_prio;
    assign wr_is_prio[0] = (wr_addr == OFS_PRIO_WORD0);
    assign wr_is_prio[1] = (wr_addr == OFS_PRIO_WORD1);
    assign wr_is_prio[2] = (wr_addr == OFS_PRIO_WORD2);
    assign wr_is_prio[3] = (wr_addr == OFS_PRIO_WORD3);
    // status is read-only, writes to it are accepted and dropped
    assign wr_err = ~(wr_is_en4 | wr_is_mask | wr_is_ext | wr_is_status | (|wr_is_prio));

    wire rd_is_en4 = (rd_addr == OFS_ENABLE_WORD4);
    wire rd_is_mask = (rd_addr == OFS_EVENT_MASK);
    wire rd_is_ext = (rd_addr == OFS_ENABLE_EXT);
    wire rd_is_status = (rd_addr == OFS_EVENT_STATUS);
    wire rd_is_p0 = (rd_addr == OFS_PRIO_WORD0);
    wire rd_is_p1 = (rd_addr == OFS_PRIO_WORD1);
    wire rd_is_p2 = (rd_addr == OFS_PRIO_WORD2);
    wire rd_is_p3 = (rd_addr == OFS_PRIO_WORD3);
    assign rd_err = ~(rd_is_en4 | rd_is_mask | rd_is_ext | rd_is_status
                      | rd_is_p0 | rd_is_p1 | rd_is_p2 | rd_is_p3);

    // ---------------------------------------------------------------
    // priority word images
    // ---------------------------------------------------------------
    wire [15:0] prio_word [N_PRIO_WORDS];
    // field order inside each word high to low; empty bits stay zero
    assign prio_word[0] = {1'b0, prio[PF_TIMER1], 1'b0, prio[PF_OUTCMP1],
                           1'b0, prio[PF_INCAP1], 1'b0, prio[PF_EXT_IRQ0]};
    assign prio_word[1] = {1'b0, prio[PF_TIMER2], 1'b0, prio[PF_OUTCMP2],
                           1'b0, prio[PF_INCAP2], 1'b0, prio[PF_DMA_CH0_DONE]};
    assign prio_word[2] = {1'b0, prio[PF_UART1_RX], 1'b0, prio[PF_SPI1_EVENT],
                           1'b0, prio[PF_SPI1_ERR], 1'b0, prio[PF_TIMER3]};
    assign prio_word[3] = {5'h00, prio[PF_DMA_CH1_DONE], 1'b0, prio[PF_ADC1_DONE],
                           1'b0, prio[PF_UART1_TX]};

    // ---------------------------------------------------------------
    // read mux
    // ---------------------------------------------------------------
    wire [15:0] en4_view = enable_word4 & ENABLE4_MASK;
    wire [31:0] rd_en4 = {16'h0000, en4_view};
    wire [31:0] rd_ext = {17'h0_0000, enable_ext};
    wire [31:0] rd_status = {11'h000, pending};
    wire [31:0] rd_mask = {11'h000, event_mask};
    wire [31:0] rd_p0 = {16'h0000, prio_word[0]};
    wire [31:0] rd_p1 = {16'h0000, prio_word[1]};
    wire [31:0] rd_p2 = {16'h0000, prio_word[2]};
    wire [31:0] rd_p3 = {16'h0000, prio_word[3]};
    assign rd_data = ({32{rd_is_en4}} & rd_en4)
                   | ({32{rd_is_ext}} & rd_ext)
                   | ({32{rd_is_status}} & rd_status)
                   | ({32{rd_is_mask}} & rd_mask)
                   | ({32{rd_is_p0}} & rd_p0)
                   | ({32{rd_is_p1}} & rd_p1)
                   | ({32{rd_is_p2}} & rd_p2)
                   | ({32{rd_is_p3}} & rd_p3);

    // ---------------------------------------------------------------
    // next values of configuration
    // ---------------------------------------------------------------
    wire [15:0] next_en4_raw = lane_merge(enable_word4, wr_data, wr_strb);
    wire [15:0] next_enable_word4 = next_en4_raw & ENABLE4_MASK;
    wire [15:0] ext_old = {1'b0, enable_ext};
    wire [15:0] ext_merged = lane_merge(ext_old, wr_data, wr_strb);
    wire [14:0] next_enable_ext = ext_merged[14:0];
    wire [31:0] mask_merged;
    assign mask_merged[15:0] = lane_merge(event_mask[15:0], wr_data, wr_strb);
    assign mask_merged[31:16] = lane_merge({11'h000, event_mask[20:16]},
                                           {16'h0000, wr_data[31:16]}, {2'b00, wr_strb[3:2]});
    wire [N_SRC-1:0] next_event_mask = mask_merged[N_SRC-1:0];

    // ---------------------------------------------------------------
    // enable-word and mask registers
    // ---------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            enable_word4 <= ENABLE4_RESET;
            enable_ext <= ENABLE_EXT_RESET;
            event_mask <= MASK_RESET;
        end else if (cken && wr_stb) begin
            if (wr_is_en4) begin
                enable_word4 <= next_enable_word4;
            end
            if (wr_is_ext) begin
                enable_ext <= next_enable_ext;
            end
            if (wr_is_mask) begin
                event_mask <= next_event_mask;
            end
        end
    end

    // ---------------------------------------------------------------
    // priority fields
    // ---------------------------------------------------------------
    for (genvar k = 0; k < N_PRIO_SRC; k++) begin : g_prio
        localparam int WORD = k / FIELDS_PER_WORD;
        localparam int LSB = (k % FIELDS_PER_WORD) * FIELD_STRIDE;
        wire [15:0] merged = lane_merge(prio_word[WORD], wr_data, wr_strb);
        // three-bit field, code equals level, 111 highest, 001 lowest
        wire [2:0] next_prio = merged[LSB +: PRIO_W];
        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                prio[k] <= PRIO_RESET;
            end else if (cken && wr_stb && wr_is_prio[WORD]) begin
                prio[k] <= next_prio;
            end
        end
    end

    // ---------------------------------------------------------------
    // sticky event status, cleared by reading it
    // ---------------------------------------------------------------
    wire status_clr = rd_stb & rd_is_status;
    wire [N_SRC-1:0] clr_vec = {N_SRC{status_clr}};
    // a new event in the clearing cycle survives the clear
    wire [N_SRC-1:0] next_pending = (pending & ~clr_vec) | src_event;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pending <= '0;
        end else if (cken) begin
            pending <= next_pending;
        end
    end

    // ---------------------------------------------------------------
    // per-source enable and level
    // ---------------------------------------------------------------
    wire [N_SRC-1:0] src_enable;
    wire [2:0] src_level [N_SRC];
    for (genvar s = 0; s < N_EN_SRC; s++) begin : g_en_src
        assign src_enable[s] = en4_view[enable4_bit(s)];
        assign src_level[s] = PRIO_ENWORD_SRC;
    end
    for (genvar k = 0; k < N_PRIO_SRC; k++) begin : g_prio_src
        assign src_enable[N_EN_SRC + k] = enable_ext[k];
        assign src_level[N_EN_SRC + k] = prio[k];
    end

    // ---------------------------------------------------------------
    // request gating toward arbitration
    // ---------------------------------------------------------------
    wire [N_SRC-1:0] level_ok;
    wire [N_SRC*PRIO_W-1:0] next_arb_level;
    for (genvar s = 0; s < N_SRC; s++) begin : g_gate
        assign level_ok[s] = level_active(src_level[s]);
        assign next_arb_level[s*PRIO_W +: PRIO_W] = src_level[s];
    end
    // enable bit and nonzero level both needed on a pending source
    wire [N_SRC-1:0] next_arb_req = pending & src_enable & level_ok;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arb_req <= '0;
            arb_level <= '0;
        end else if (cken) begin
            arb_req <= next_arb_req;
            arb_level <= next_arb_level;
        end
    end

    // ---------------------------------------------------------------
    // interrupt output
    // ---------------------------------------------------------------
    wire next_irq = |(next_pending & event_mask);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq <= 1'b0;
        end else if (cken) begin
            irq <= next_irq;
        end
    end

endmodule : irq_enable_priority_regs

// file: bench/irq_cfg_properties.sv
// assertions on the ports of irq_enable_priority_regs
// assumes one aclk domain; bound at the foot of this file
`timescale 1ns/1ps
module irq_cfg_properties
    import irq_cfg_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic cken,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [DATA_W-1:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [N_SRC-1:0] arb_req,
    input wire logic [N_SRC*PRIO_W-1:0] arb_level,
    input wire logic irq
);
    logic [N_SRC-1:0] lvl_zero;
    for (genvar i = 0; i < N_SRC; i++) begin : g_zero
        assign lvl_zero[i] = arb_level[3*i+:3] == 3'h0;
    end
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    property p_rst; $rose(aresetn) |-> arb_req == '0 && !irq; endproperty
    a_rst: assert property (p_rst) else $error("not idle after reset");
    property p_zero; (arb_req & lvl_zero & $past(lvl_zero)) == '0; endproperty
    a_zero: assert property (p_zero) else $error("request at level zero");
    property p_rd_hi; s_axi_rvalid |-> s_axi_rdata[31:21] == 11'h000; endproperty
    a_rd_hi: assert property (p_rd_hi) else $error("upper read bits set");
    property p_wr; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && cken
        |-> ##[1:3] s_axi_bvalid; endproperty
    a_wr: assert property (p_wr) else $error("write response late");
    property p_bhold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
    a_bhold: assert property (p_bhold) else $error("write response dropped");
    property p_rd; s_axi_arvalid && s_axi_arready && cken |-> ##[1:3] s_axi_rvalid; endproperty
    a_rd: assert property (p_rd) else $error("read response late");
    property p_rhold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    a_rhold: assert property (p_rhold) else $error("read data not held");
    property p_busy; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
    a_busy: assert property (p_busy) else $error("write taken while busy");
    property p_freeze; !cken |=> $stable(arb_req) && $stable(irq); endproperty
    a_freeze: assert property (p_freeze) else $error("outputs moved while frozen");
endmodule : irq_cfg_properties
bind irq_enable_priority_regs irq_cfg_properties props (.*);

// file: bench/event_src_model.sv
// stand-in for the peripheral request sources
// assumes requests on aclk; one-cycle burst per fire
`timescale 1ns/1ps
module event_src_model
    import irq_cfg_pkg::*;
(
    input wire logic aclk,
    input wire logic fire,
    input wire logic [N_SRC-1:0] sel,
    output logic [N_SRC-1:0] src_event
);
    initial src_event = '0;
    always @(posedge aclk) begin
        src_event <= fire ? sel : '0;
    end
endmodule : event_src_model

// file: bench/tb.sv
// self-checking bench for irq_enable_priority_regs
// assumes the source model and bound checker are compiled first
`timescale 1ns/1ps
module tb
    import irq_cfg_pkg::*;
;
    logic aclk = 0;
    logic aresetn = 0;
    logic cken = 1;
    logic fire = 0;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic s_axi_arvalid = 0, s_axi_rready = 0;
    logic [ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0, a;
    logic [DATA_W-1:0] s_axi_wdata = '0, s_axi_rdata, d;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [N_SRC-1:0] sel = '0, src_event, arb_req, req;
    logic [N_SRC*PRIO_W-1:0] arb_level;
    logic [15:0] w [4];
    logic [2:0] lv;
    logic [33:0] expq [$];
    int error_cnt = 0;
    int checks = 0;
    int bp [6] = '{7, 6, 5, 4, 2, 1};
    always #2 aclk = ~aclk;
    event_src_model src (.aclk(aclk), .fire(fire), .sel(sel), .src_event(src_event));
    irq_enable_priority_regs dut (.*);
    task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
        checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic wr(input logic [11:0] ad, input logic [31:0] v);
        expq.push_back(34'(ad > OFS_ENABLE_EXT ? RESP_SLVERR : RESP_OKAY));
        @(posedge aclk);
        s_axi_awaddr <= ad;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do @(negedge aclk); while (!(s_axi_awready && s_axi_wready));
        @(posedge aclk);
        s_axi_awvalid <= 1'b0;
        s_axi_wvalid <= 1'b0;
        do @(negedge aclk); while (!s_axi_bvalid);
        @(posedge aclk);
        s_axi_bready <= 1'b1;
        @(posedge aclk);
        s_axi_bready <= 1'b0;
    endtask : wr
    task automatic rd(input logic [11:0] ad, input logic [31:0] e);
        expq.push_back({ad > OFS_ENABLE_EXT ? RESP_SLVERR : RESP_OKAY, e});
        @(posedge aclk);
        s_axi_araddr <= ad;
        s_axi_arvalid <= 1'b1;
        do @(negedge aclk); while (!s_axi_arready);
        @(posedge aclk);
        s_axi_arvalid <= 1'b0;
        do @(negedge aclk); while (!s_axi_rvalid);
        @(posedge aclk);
        s_axi_rready <= 1'b1;
        @(posedge aclk);
        s_axi_rready <= 1'b0;
    endtask : rd
    task automatic pulse(input logic [N_SRC-1:0] s);
        sel <= s;
        fire <= 1'b1;
        @(posedge aclk);
        fire <= 1'b0;
        repeat (3) @(posedge aclk);
        @(negedge aclk);
    endtask : pulse
    task automatic results;
        $display("checks %0d errors %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : results
    always @(posedge aclk) begin
        if (s_axi_rvalid && s_axi_rready)
            chk({s_axi_rresp, s_axi_rdata}, expq.pop_front());
        if (s_axi_bvalid && s_axi_bready)
            chk(34'(s_axi_bresp), expq.pop_front());
    end
    initial begin
        #40000;
        error_cnt++;
        results();
    end
    initial begin
        void'($urandom(32'hc084));
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        rd(OFS_ENABLE_WORD4, 32'h0000_0000);
        for (int k = 0; k < 4; k++)
            rd(OFS_PRIO_WORD0 + 12'(4 * k), k < 3 ? 32'h0000_4444 : 32'h0000_0444);
        wr(OFS_ENABLE_WORD4, 32'hffff_ffff);
        rd(OFS_ENABLE_WORD4, 32'h0000_00f6);
        wr(OFS_ENABLE_EXT, 32'h0000_7fff);
        wr(OFS_EVENT_MASK, 32'h001f_ffff);
        for (int r = 0; r < 8; r++) begin
            for (int k = 0; k < 4; k++) begin
                d = r == 0 ? 32'h0000_0000 : r == 1 ? 32'hffff_ffff : $urandom;
                w[k] = d[15:0];
                a = OFS_PRIO_WORD0 + 12'(4 * k);
                wr(a, d);
                rd(a, d & {16'h0000, k < 3 ? 4'h7 : 4'h0, 12'h777});
            end
            pulse(21'h1f_ffff);
            req = 21'h00_003f;
            for (int s = 0; s < N_SRC; s++) begin
                lv = s < 6 ? PRIO_ENWORD_SRC : w[(s - 6) / 4][4 * ((s - 6) % 4) +: 3];
                chk(34'(arb_level[3 * s +: 3]), 34'(lv));
                req[s] = lv != 3'h0;
            end
            chk({12'h000, irq, arb_req}, {12'h000, 1'b1, req});
        end
        wr(OFS_ENABLE_EXT, 32'h0000_0000);
        rd(OFS_EVENT_STATUS, 32'h001f_ffff);
        for (int s = 0; s < 6; s++) begin
            wr(OFS_ENABLE_WORD4, ~(32'h1 << bp[s]));
            wr(OFS_EVENT_MASK, 32'(s % 2) << s);
            pulse(21'h00_003f);
            req = 21'h00_003f & ~(21'h1 << s);
            chk({12'h000, irq, arb_req}, {12'h000, 1'(s % 2), req});
            rd(OFS_EVENT_STATUS, 32'h0000_003f);
        end
        @(negedge aclk);
        chk(34'(irq), 34'h0);
        @(posedge aclk);
        cken <= 1'b0;
        pulse(21'h00_0020);
        @(posedge aclk);
        cken <= 1'b1;
        rd(OFS_EVENT_STATUS, 32'h0000_0000);
        wr(12'h020, 32'hffff_ffff);
        rd(12'h020, 32'h0000_0000);
        @(posedge aclk);
        results();
    end
endmodule : tb
